// ===== tdh_defs.vh
`ifndef TDH_DEFS_VH
`define TDH_DEFS_VH
// dot oscillator in kHz
`define TDH_DOT_FREQ_KHZ 9828
`define TDH_DOTS_PER_SLOT 3'h6
`define TDH_DOT_LAST 3'h5
`define TDH_SLOTS_PER_LINE 7'h69
`define TDH_SLOT_LAST 7'h68
`define TDH_SLOT_GATE_ON 7'h02
`define TDH_SLOT_GATE_OFF 7'h52
`define TDH_SLOT_ROW_ADV 7'h51
`define TDH_SLOT_SYNC_INT 7'h54
`define TDH_SLOT_HSYNC_ON 7'h58
`define TDH_SLOT_HSYNC_OFF 7'h14
`define TDH_SLOT_RESET 7'h00
`define TDH_DOT_RESET 3'h0
`define TDH_BIT_W2 1
`define TDH_BIT_W64 6
`define TDH_GATE_RESET 1'h0
`define TDH_HSYNC_RESET 1'h0
`define TDH_SYNC_RESET 1'h0
`define TDH_ROW_RESET 1'h0
`define TDH_STROBE_IDLE 1'h1
`define TDH_EDGE_RESET 1'h0
`endif

// ===== tdh_dot_divider.v
`timescale 1ns/1ps
`include "tdh_defs.vh"
module tdh_dot_divider (
   // clock and reset
   input wire sys_clk,
   input wire reset,
   // dot phase and slot advance
   output reg [2:0] dot_count_reg,
   output reg slot_advance_reg
);
   reg [2:0] dot_count_next;

   always @* begin
      if (dot_count_reg == `TDH_DOT_LAST) begin
         dot_count_next = `TDH_DOT_RESET;
      end else begin
         dot_count_next = dot_count_reg + 3'h1;
      end
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         dot_count_reg <= `TDH_DOT_RESET;
         slot_advance_reg <= 1'b0;
      end else begin
         dot_count_reg <= dot_count_next;
         slot_advance_reg <= (dot_count_reg == `TDH_DOT_LAST);
      end
   end
endmodule // tdh_dot_divider

// ===== tdh_horizontal_timing.v
// How it works
// - sys_clk is the dot clock
// - modulo-six dot divider gives slot advance
// - slot advance strobe is active low, one whole dot
// - 105 slots per line, 80 displayed
// - gate opens at slot 2
// - gate closes at slot 82
// - sync interval from 84 until wrap
// - counter reloads zero after 104
// - seven-bit count, decode compares all bits 0-6
// - gate flop clocks on weight-2 rise
// - gated char strobes and shift pulses
// - row advance pulse at slot 81
// - hsync asserts at 88, ends at 20
// - vertical enable input bounds active lines
`timescale 1ns/1ps
`include "tdh_defs.vh"
module tdh_horizontal_timing (
   // clock and reset
   input wire sys_clk,
   input wire reset,
   // vertical section
   input wire vert_display_enable,
   // video path
   output reg dot_gate_flop,
   output reg char_strobe_n,
   output reg shift_pulse_n,
   output reg slot_advance_n,
   output reg [6:0] slot_count,
   // margins and sync
   output reg sync_interval,
   output reg hsync,
   // character scan-line counter
   output reg row_advance_flop
);
   // line regions; the sync interval output is high in the last one
   localparam [1:0] REGION_LEFT = 2'h0;
   localparam [1:0] REGION_ACTIVE = 2'h1;
   localparam [1:0] REGION_RIGHT = 2'h2;
   localparam [1:0] REGION_SYNC = 2'h3;

   // slot advance from the dot divider
   wire slot_advance;

   // slot counter and region
   reg [6:0] slot_next;
   reg [1:0] region_reg;
   reg [1:0] region_next;

   // gate flop control
   reg w2_prev_reg;
   reg w2_rise;
   reg gate_load;
   reg gate_clear;
   reg gate_next;

   // next values of the registered outputs
   reg hsync_next;
   reg sync_next;
   reg row_next;
   reg strobe_next;
   reg shift_next;

   // one sys_clk per dot; half-dot pulses become one-cycle low pulses
   // the dot phase itself is not needed here, only the advance
   tdh_dot_divider tdh_dot_divider_i (
      .sys_clk(sys_clk),
      .reset(reset),
      .dot_count_reg(),
      .slot_advance_reg(slot_advance)
   );

   // upper five bits pick the decode group, the low two bits pin the slot
   // inside it, since not every stated edge falls on a group boundary
   function is_slot;
      input [6:0] cnt;
      input [6:0] val;
      begin
         is_slot = (cnt[6:2] == val[6:2]) && (cnt[1:0] == val[1:0]);
      end
   endfunction

   // true on the advance that takes the count onto the given slot
   function enters_slot;
      input adv;
      input [6:0] nxt;
      input [6:0] val;
      begin
         enters_slot = adv && is_slot(nxt, val);
      end
   endfunction

   // modulo-105 slot count
   always @* begin
      if (slot_count == `TDH_SLOT_LAST) begin
         slot_next = `TDH_SLOT_RESET;
      end else begin
         slot_next = slot_count + 7'h01;
      end
   end

   // region steps only on an advance, to the region that slot_next opens
   always @* begin
      region_next = region_reg;
      case (region_reg)
         REGION_LEFT: begin
            if (enters_slot(slot_advance, slot_next, `TDH_SLOT_GATE_ON)) begin
               region_next = REGION_ACTIVE;
            end
         end
         REGION_ACTIVE: begin
            if (enters_slot(slot_advance, slot_next, `TDH_SLOT_GATE_OFF)) begin
               region_next = REGION_RIGHT;
            end
         end
         REGION_RIGHT: begin
            if (enters_slot(slot_advance, slot_next, `TDH_SLOT_SYNC_INT)) begin
               region_next = REGION_SYNC;
            end
         end
         REGION_SYNC: begin
            if (enters_slot(slot_advance, slot_next, `TDH_SLOT_RESET)) begin
               region_next = REGION_LEFT;
            end
         end
         default: begin
            region_next = REGION_LEFT;
         end
      endcase
   end

   // sync interval
   always @* begin
      sync_next = (region_next == REGION_SYNC);
   end

   // hsync spans the wrap, so it is a set/clear pair and not a range test
   always @* begin
      hsync_next = hsync;
      if (enters_slot(slot_advance, slot_next, `TDH_SLOT_HSYNC_ON)) begin
         hsync_next = 1'h1;
      end else if (enters_slot(slot_advance, slot_next, `TDH_SLOT_HSYNC_OFF)) begin
         hsync_next = 1'h0;
      end
   end

   // one pulse for the scan-line counter as the last character slot (slot 81) begins
   always @* begin
      row_next = enters_slot(slot_advance, slot_next, `TDH_SLOT_ROW_ADV);
   end

   // only the weight-2 rise at slot 2 loads the gate; later rises would reload
   // the same level, so a mid-line change of the enable waits for the next line
   always @* begin
      w2_rise = slot_count[`TDH_BIT_W2] && !w2_prev_reg && !slot_count[`TDH_BIT_W64];
      gate_load = w2_rise && is_slot(slot_count, `TDH_SLOT_GATE_ON);
      gate_clear = is_slot(slot_count, `TDH_SLOT_GATE_OFF);
      if (gate_load) begin
         gate_next = vert_display_enable;
      end else if (gate_clear) begin
         gate_next = 1'h0;
      end else begin
         gate_next = dot_gate_flop;
      end
   end

   // video path pulses, both held off while the gate is clear
   always @* begin
      strobe_next = ~(dot_gate_flop && slot_advance);
      shift_next = ~dot_gate_flop;
   end

   // slot counter, region and the weight-2 history
   always @(posedge sys_clk) begin
      if (reset) begin
         slot_count <= `TDH_SLOT_RESET;
         region_reg <= REGION_LEFT;
         w2_prev_reg <= `TDH_EDGE_RESET;
      end else begin
         if (slot_advance) begin
            slot_count <= slot_next;
         end
         region_reg <= region_next;
         w2_prev_reg <= slot_count[`TDH_BIT_W2];
      end
   end

   // dot gate
   always @(posedge sys_clk) begin
      if (reset) begin
         dot_gate_flop <= `TDH_GATE_RESET;
      end else begin
         dot_gate_flop <= gate_next;
      end
   end

   // monitor sync, sync interval and the scan-line advance
   // all change on the advance edge, together with slot_count, except the scan-line pulse, which falls one cycle later
   always @(posedge sys_clk) begin
      if (reset) begin
         hsync <= `TDH_HSYNC_RESET;
         sync_interval <= `TDH_SYNC_RESET;
         row_advance_flop <= `TDH_ROW_RESET;
      end else begin
         hsync <= hsync_next;
         sync_interval <= sync_next;
         row_advance_flop <= row_next;
      end
   end

   // active-low pulses; each lasts one whole dot cycle instead of half a dot
   // because there is no second clock edge to time the half
   always @(posedge sys_clk) begin
      if (reset) begin
         slot_advance_n <= `TDH_STROBE_IDLE;
         char_strobe_n <= `TDH_STROBE_IDLE;
         shift_pulse_n <= `TDH_STROBE_IDLE;
      end else begin
         slot_advance_n <= ~slot_advance;
         char_strobe_n <= strobe_next;
         shift_pulse_n <= shift_next;
      end
   end
endmodule // tdh_horizontal_timing

// ===== tdh_asserts.sv
`timescale 1ns/1ps
module tdh_asserts (
   // clock and reset
   input wire sys_clk,
   input wire reset,
   // vertical section
   input wire vert_display_enable,
   // video path
   input wire dot_gate_flop,
   input wire char_strobe_n,
   input wire shift_pulse_n,
   input wire slot_advance_n,
   input wire [6:0] slot_count,
   // margins and sync
   input wire sync_interval,
   input wire hsync,
   // character scan-line counter
   input wire row_advance_flop
);
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
sequence s_gap; slot_advance_n [*5] ##1 !slot_advance_n; endsequence
property p_adv; $fell(slot_advance_n) |=> s_gap; endproperty
a_adv: assert property (p_adv) else $error("slot advance spacing");
property p_wrap; $changed(slot_count) |-> !slot_advance_n &&
   slot_count == ($past(slot_count) == 7'h68 ? 7'h00 : $past(slot_count) + 7'h01); endproperty
a_wrap: assert property (p_wrap) else $error("slot step");
property p_gload; $changed(slot_count) && slot_count == 7'h02 |=>
   dot_gate_flop == $past(vert_display_enable); endproperty
a_gload: assert property (p_gload) else $error("gate load");
property p_goff; slot_count == 7'h52 |=> !dot_gate_flop; endproperty
a_goff: assert property (p_goff) else $error("gate clear");
property p_shift; shift_pulse_n != $past(dot_gate_flop); endproperty
a_shift: assert property (p_shift) else $error("shift gating");
// one character strobe per slot advance, only while the gate was open
property p_strobe; char_strobe_n == !(!slot_advance_n && $past(dot_gate_flop)); endproperty
a_strobe: assert property (p_strobe) else $error("char strobe gating");
property p_row; $rose(row_advance_flop) |-> slot_count == 7'h51 ##1 !row_advance_flop;
endproperty
a_row: assert property (p_row) else $error("row pulse");
property p_hs; $changed(hsync) |-> slot_count == (hsync ? 7'h58 : 7'h14); endproperty
a_hs: assert property (p_hs) else $error("hsync edge");
property p_sync; $changed(sync_interval) |-> slot_count == (sync_interval ? 7'h54 : 7'h00);
endproperty
a_sync: assert property (p_sync) else $error("sync interval");
// reset itself is the cause here, so it must not disable the check
property p_rst; disable iff (1'b0) reset |=> slot_count == 7'h00 && !hsync && !dot_gate_flop;
endproperty
a_rst: assert property (p_rst) else $error("reset state");
endmodule // tdh_asserts
bind tdh_horizontal_timing tdh_asserts tdh_asserts_i(.*);

// ===== tdh_monitor.sv
`timescale 1ns/1ps
module tdh_monitor(input wire hsync, output integer lines);
initial lines = 0;
always @(posedge hsync) lines = lines + 1;
endmodule // tdh_monitor

// ===== tb_tdh_horizontal_timing.sv
`timescale 1ns/1ps
module tb_tdh_horizontal_timing;
reg sys_clk, reset, vde;
wire gate, strb, shft, adv, syn, hs, row;
wire [6:0] slot;
integer fails, cmp_count, cyc, lines, strobes, shifts;
tdh_horizontal_timing tdh_horizontal_timing_i(.sys_clk(sys_clk), .reset(reset),
   .vert_display_enable(vde), .dot_gate_flop(gate), .char_strobe_n(strb),
   .shift_pulse_n(shft), .slot_advance_n(adv), .slot_count(slot),
   .sync_interval(syn), .hsync(hs), .row_advance_flop(row));
tdh_monitor tdh_monitor_i(.hsync(hs), .lines(lines));
task close_out;
   begin
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   end
endtask
task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
   begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("MISMATCH %0s exp %0d got %0d", nm, e, g);
      end
   end
endtask
// bounded so a stuck counter ends in the timeout, not a hang
task upto(input [6:0] s);
   integer n;
   begin
      n = 0;
      while (slot !== s && n < 700) begin @(negedge sys_clk); n = n + 1; end
      chk("slot", s, slot);
   end
endtask
task t_line(input v);
   begin
      vde = v;
      upto(1);
      strobes = 0;
      shifts = 0;
      upto(40); chk("gate", v, gate);
      upto(81);
      chk("row", 1, row);
      @(negedge sys_clk);
      chk("row", 0, row);
      upto(83); chk("gate", 0, gate);
      chk("strobes", v ? 80 : 0, strobes[15:0]);
      chk("shifts", v ? 480 : 0, shifts[15:0]);
      chk("syncint", 0, syn);
      upto(90); chk("hsync", 1, hs);
      chk("syncint", 1, syn);
      upto(21); chk("hsync", 0, hs);
      chk("syncint", 0, syn);
   end
endtask
// reset in mid-line; vde is expected high so the gate is open before slot 82
task t_reset(input [6:0] at);
   begin
      upto(at);
      chk("gate", at < 7'h52, gate);
      chk("hsync", at >= 7'h58, hs);
      reset = 1;
      repeat (3) @(negedge sys_clk);
      chk("slot", 0, slot);
      chk("gate", 0, gate);
      chk("hsync", 0, hs);
      chk("syncint", 0, syn);
      reset = 0;
   end
endtask
// each video pulse is low for one whole cycle, so one negedge sees it
always @(negedge sys_clk) begin
   if (strb === 1'b0) strobes = strobes + 1;
   if (shft === 1'b0) shifts = shifts + 1;
end
initial begin sys_clk = 0; forever #12.5 sys_clk = ~sys_clk; end
initial begin
   reset = 1; vde = 0; fails = 0; cmp_count = 0; cyc = 0;
   strobes = 0;
   shifts = 0;
   repeat (20) @(negedge sys_clk);
   chk("slot", 0, slot);
   reset = 0;
   t_line(1);
   t_line(0);
   t_line(1);
   chk("lines", 5, lines[15:0]);
   t_reset(7'h32);
   t_reset(7'h5F);
   t_line(1);
   chk("lines", 7, lines[15:0]);
   close_out;
end
always @(posedge sys_clk) begin
   cyc = cyc + 1;
   if (cyc == 6000) begin
      fails = fails + 1;
      $display("MISMATCH run_cycles exp %0d got %0d", 5999, cyc);
      close_out;
   end
end
endmodule // tb_tdh_horizontal_timing
